//--- core/gsfs_pkg.sv
// Shared constants of the general-purpose pin block
`default_nettype none
package gsfs_pkg;
  // Register indices on the register port
  localparam logic [2:0] REG_DIR = 3'h0;
  localparam logic [2:0] REG_LEVEL = 3'h1;
  localparam logic [2:0] REG_CHAIN = 3'h2;
  localparam logic [2:0] REG_SFCFG = 3'h3;
  localparam logic [2:0] REG_SYNC = 3'h4;
  localparam logic [7:0] RST_REG = 8'h00;
  // Special function config bits
  localparam int SF_MUX = 0;
  localparam int SF_BUSY = 1;
  localparam int SF_FAULT = 2;
  localparam int SF_INTOUT = 3;
  localparam int SF_EXTIN = 4;
  localparam logic [7:0] SF_USED = 8'h1F;
  // Sync config fields
  localparam int SY_DIV_LSB = 0;
  localparam int SY_DIV_W = 6;
  localparam int SY_CLKSEL = 6;
  localparam int SY_POL = 7;
  // Pins with special roles
  localparam int PIN_MUX0 = 0;
  localparam int PIN_MUX1 = 1;
  localparam int PIN_BUSY = 2;
  localparam int PIN_FAULT = 3;
  localparam int PIN_CLK = 4;
  // Round pointer value that selects the device itself
  localparam logic [2:0] PTR_DEV = 3'h7;
  // Clock rates
  localparam longint CLK_HZ = 100_000_000;
  localparam longint MCLK_HZ = 1_000_000;
  localparam longint CHOP_HZ = 125_000;
  localparam longint EXT_MAX_HZ = 32_000_000;
  localparam int MCLK_DIV = int'(CLK_HZ / MCLK_HZ);
  localparam int CHOP_DIV = int'(MCLK_HZ / CHOP_HZ);
endpackage
`default_nettype wire

//--- core/gsfs_sync.sv
// Two-flop synchroniser for pin levels
`default_nettype none
module gsfs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gsfs_sync_s;

  gsfs_sync_s st_r;
  gsfs_sync_s st_nxt;

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= {INIT, INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule // gsfs_sync
`default_nettype wire

//--- core/gsfs_extdiv.sv
// Divider for the outside clock, on both of its edges
`default_nettype none
module gsfs_extdiv #(
  parameter int DW = gsfs_pkg::SY_DIV_W
) (
  input wire logic ext_clk,
  input wire logic srst,
  input wire logic [DW-1:0] div_cfg,
  output logic tgl_pos,
  output logic tgl_neg
);
  typedef struct packed {
    logic [1:0] rs;
    logic [DW-1:0] d1;
    logic [DW-1:0] d2;
    logic [DW-1:0] cnt;
    logic tgl;
  } gsfs_ediv_s;

  gsfs_ediv_s st_r;
  gsfs_ediv_s st_nxt;
  logic [DW-1:0] lim;
  logic [DW-1:0] ncnt_r;
  logic ntgl_r;

  // Divide by the field; zero acts as one
  assign lim = (st_r.d2 == '0) ? '0 : DW'(st_r.d2 - 1'b1); // see RULE11

  always_comb begin
    st_nxt = st_r;
    st_nxt.rs = {st_r.rs[0], srst};
    st_nxt.d1 = div_cfg;
    st_nxt.d2 = st_r.d1;
    if (st_r.rs[1] || st_r.cnt >= lim) begin
      st_nxt.cnt = '0;
      st_nxt.tgl = st_r.rs[1] ? 1'b0 : ~st_r.tgl;
    end else begin
      st_nxt.cnt = DW'(st_r.cnt + 1'b1);
    end
  end

  always_ff @(posedge ext_clk) begin
    st_r <= st_nxt;
  end

  // Same division counted on falling edges
  always_ff @(negedge ext_clk) begin
    if (st_r.rs[1]) begin
      ncnt_r <= '0;
      ntgl_r <= 1'b0;
    end else if (ncnt_r >= lim) begin
      ncnt_r <= '0;
      ntgl_r <= ~ntgl_r; // see RULE12
    end else begin
      ncnt_r <= DW'(ncnt_r + 1'b1);
    end
  end

  assign tgl_pos = st_r.tgl;
  assign tgl_neg = ntgl_r;
endmodule // gsfs_extdiv
`default_nettype wire

//--- core/gsfs_top.sv
// General-purpose pins with special functions and chained chip select
`default_nettype none
// Overview of operation
// RULE1: One direction bit per pin, set is output
// RULE2: Level register drives outputs, reads sampled inputs
// RULE3: Seven pins, or five in smaller package
// RULE4: Pins 0 and 1 follow external mux field
// RULE5: Pin 2 shows calibration busy when enabled
// RULE6: Pin 3 shows OR of all error flags
// RULE7: Chopping clock 125 kHz from 1 MHz master
// RULE8: Clock out needs output, clock-out set, clock-in clear
// RULE9: Select bit picks chopping or master clock
// RULE10: Clock in needs input, clock-in set, clock-out clear
// RULE11: Outside clock 1 to 32 MHz, divided to 1 MHz
// RULE12: Polarity bit picks rising or falling outside edge
// RULE13: Chain bit needs output pin, no other function
// RULE14: Host pulses go to chained pins ascending, then device
// RULE15: Round restarts at lowest chained pin, repeats
// RULE16: Serial output released unless device is selected
// RULE17: Serial frames and checksums pass unchanged
// RULE18: Host shares its one select and serial lines
// RULE19: Reset leaves inputs, no special functions
// RULE20: Round advances only on select release edge
module gsfs_top #(
  parameter int NPIN = 7,
  parameter int NERR = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ext_clk,
  input wire logic reg_wr,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [NPIN-1:0] gpio_in,
  output logic [NPIN-1:0] gpio_out,
  output logic [NPIN-1:0] gpio_oe_n,
  input wire logic host_cs_n,
  output logic core_cs_n,
  input wire logic sdo_core,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic [1:0] outside_selector_field_field,
  input wire logic cal_busy,
  input wire logic [NERR-1:0] err_flags,
  output logic master_tick
);
  localparam logic [7:0] PIN_MASK = 8'((1 << NPIN) - 1); // see RULE3
  localparam int SW = NPIN + 3;
  localparam logic [SW-1:0] SYNC_INIT = SW'(1) << NPIN;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] level;
    logic [7:0] chain;
    logic [7:0] sfcfg;
    logic [7:0] sync;
    logic [7:0] out;
    logic [7:0] rdata;
    logic [2:0] ptr;
    logic [6:0] icnt;
    logic [2:0] ccnt;
    logic mclk;
    logic chop;
    logic tprev;
    logic cprev;
    logic dcs;
    logic sdo;
    logic mtick;
  } gsfs_top_s;

  gsfs_top_s st_r;
  gsfs_top_s st_nxt;
  logic [SW-1:0] sync_q;
  logic [NPIN-1:0] pin_s;
  logic cs_s;
  logic tgl_p;
  logic tgl_n;
  logic tgl_sel;
  logic ext_mode;
  logic clk_on;
  logic cs_rise;
  logic cfg_chg;
  logic int_tick;
  logic tick;

  localparam int PIN_MUX0 = gsfs_pkg::PIN_MUX0;
  localparam int PIN_MUX1 = gsfs_pkg::PIN_MUX1;
  localparam int PIN_BUSY = gsfs_pkg::PIN_BUSY;
  localparam int PIN_FAULT = gsfs_pkg::PIN_FAULT;
  localparam int PIN_CLK = gsfs_pkg::PIN_CLK;

  // Pins that hold a special function
  function automatic logic [7:0] pin_sf(input logic [7:0] cfg, input logic [7:0] dir);
    logic [7:0] m;
    m = 8'h00;
    m[PIN_MUX0] = cfg[gsfs_pkg::SF_MUX];
    m[PIN_MUX1] = cfg[gsfs_pkg::SF_MUX];
    m[PIN_BUSY] = cfg[gsfs_pkg::SF_BUSY];
    m[PIN_FAULT] = cfg[gsfs_pkg::SF_FAULT];
    m[PIN_CLK] = cfg[gsfs_pkg::SF_INTOUT] | cfg[gsfs_pkg::SF_EXTIN];
    return m;
  endfunction

  // Next chained pin above cur, the lowest one when cur is the device, or the device when none is left
  function automatic logic [2:0] next_chain(input logic [7:0] m, input logic [2:0] cur);
    logic [2:0] r;
    logic hit;
    r = gsfs_pkg::PTR_DEV;
    hit = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (!hit && m[i] && (cur == gsfs_pkg::PTR_DEV || i > int'(cur))) begin
        r = 3'(i);
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  gsfs_sync #(
    .W(SW),
    .INIT(SYNC_INIT)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .d({tgl_n, tgl_p, host_cs_n, gpio_in}),
    .q(sync_q)
  );

  gsfs_extdiv #(
    .DW(gsfs_pkg::SY_DIV_W)
  ) u_extdiv (
    .ext_clk(ext_clk),
    .srst(srst),
    .div_cfg(st_r.sync[gsfs_pkg::SY_DIV_LSB +: gsfs_pkg::SY_DIV_W]), // see RULE11
    .tgl_pos(tgl_p),
    .tgl_neg(tgl_n)
  );

  assign pin_s = sync_q[NPIN-1:0];
  assign cs_s = sync_q[NPIN];
  assign tgl_sel = st_r.sync[gsfs_pkg::SY_POL] ? sync_q[NPIN+1] : sync_q[NPIN+2]; // see RULE12
  assign ext_mode = st_r.sfcfg[gsfs_pkg::SF_EXTIN] & ~st_r.sfcfg[gsfs_pkg::SF_INTOUT] &
    ~st_r.dir[PIN_CLK]; // see RULE10
  assign clk_on = st_r.dir[PIN_CLK] & st_r.sfcfg[gsfs_pkg::SF_INTOUT] &
    ~st_r.sfcfg[gsfs_pkg::SF_EXTIN]; // see RULE8
  assign cs_rise = cs_s & ~st_r.cprev;
  assign int_tick = st_r.icnt == 7'(gsfs_pkg::MCLK_DIV - 1);
  assign tick = ext_mode ? (tgl_sel != st_r.tprev) : int_tick;

  always_comb begin
    st_nxt = st_r;
    cfg_chg = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        gsfs_pkg::REG_DIR: st_nxt.dir = reg_wdata & PIN_MASK; // see RULE1
        gsfs_pkg::REG_LEVEL: st_nxt.level = reg_wdata & PIN_MASK; // see RULE2
        gsfs_pkg::REG_CHAIN: st_nxt.chain = reg_wdata;
        gsfs_pkg::REG_SFCFG: st_nxt.sfcfg = reg_wdata & gsfs_pkg::SF_USED;
        gsfs_pkg::REG_SYNC: st_nxt.sync = reg_wdata;
        default: st_nxt.dir = st_r.dir;
      endcase
    end
    // Chain only on output pins free of other functions
    st_nxt.chain = st_nxt.chain & st_nxt.dir & PIN_MASK &
      ~pin_sf(st_nxt.sfcfg, st_nxt.dir); // see RULE13
    cfg_chg = st_nxt.chain != st_r.chain;
    // Master clock from the internal count or the divided outside clock
    st_nxt.icnt = int_tick ? 7'h00 : 7'(st_r.icnt + 1'b1);
    st_nxt.mclk = st_r.icnt < 7'(gsfs_pkg::MCLK_DIV / 2);
    st_nxt.tprev = tgl_sel;
    st_nxt.mtick = tick;
    if (tick) begin
      st_nxt.ccnt = 3'(st_r.ccnt + 1'b1); // see RULE7
    end
    st_nxt.chop = st_r.ccnt[2];
    // Pin output levels
    st_nxt.out = st_r.level; // see RULE2
    if (st_r.sfcfg[gsfs_pkg::SF_MUX]) begin
      st_nxt.out[PIN_MUX1:PIN_MUX0] = outside_selector_field_field; // see RULE4
    end
    if (st_r.sfcfg[gsfs_pkg::SF_BUSY]) begin
      st_nxt.out[PIN_BUSY] = cal_busy; // see RULE5
    end
    if (st_r.sfcfg[gsfs_pkg::SF_FAULT]) begin
      st_nxt.out[PIN_FAULT] = |err_flags; // see RULE6
    end
    if (clk_on) begin
      st_nxt.out[PIN_CLK] = st_r.sync[gsfs_pkg::SY_CLKSEL] ? st_r.chop : st_r.mclk; // see RULE9
    end
    // Chained pins mirror the host select while selected; frames are not touched
    for (int i = 0; i < 7; i++) begin
      if (st_r.chain[i]) begin
        st_nxt.out[i] = cs_s | (st_r.ptr != 3'(i)); // see RULE14 see RULE17
      end
    end
    st_nxt.dcs = cs_s | (st_r.ptr != gsfs_pkg::PTR_DEV);
    st_nxt.sdo = sdo_core; // see RULE17
    // Round pointer
    st_nxt.cprev = cs_s;
    if (cfg_chg) begin
      st_nxt.ptr = gsfs_pkg::PTR_DEV; // see RULE15
    end else if (cs_rise) begin
      st_nxt.ptr = next_chain(st_r.chain, st_r.ptr); // see RULE20 see RULE15
    end
    // Read data
    case (reg_addr)
      gsfs_pkg::REG_DIR: st_nxt.rdata = st_r.dir;
      gsfs_pkg::REG_LEVEL: st_nxt.rdata = (st_r.dir & st_r.level) |
        (~st_r.dir & 8'(pin_s)); // see RULE2
      gsfs_pkg::REG_CHAIN: st_nxt.rdata = st_r.chain;
      gsfs_pkg::REG_SFCFG: st_nxt.rdata = st_r.sfcfg;
      gsfs_pkg::REG_SYNC: st_nxt.rdata = st_r.sync;
      default: st_nxt.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0; // see RULE19
      st_r.ptr <= gsfs_pkg::PTR_DEV;
      st_r.out <= 8'hFF;
      st_r.cprev <= 1'b1;
      st_r.dcs <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign gpio_out = st_r.out[NPIN-1:0];
  assign gpio_oe_n = ~st_r.dir[NPIN-1:0]; // see RULE1
  assign core_cs_n = st_r.dcs;
  assign sdo_out = st_r.sdo;
  assign sdo_oe_n = st_r.dcs; // see RULE16 see RULE18
  assign master_tick = st_r.mtick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_dir;
    reg_wr && reg_addr == gsfs_pkg::REG_DIR |=> gpio_oe_n == ~$past(reg_wdata[NPIN-1:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction write not applied"); // see RULE1

  property p_read;
    !st_r.dir[1] && reg_addr == gsfs_pkg::REG_LEVEL |=> reg_rdata[1] == $past(pin_s[1]);
  endproperty
  a_read: assert property (p_read) else $error("input level read wrong"); // see RULE2

  property p_level;
    !st_r.sfcfg[gsfs_pkg::SF_MUX] && !st_r.chain[0] |=> gpio_out[0] == $past(st_r.level[0]);
  endproperty
  a_level: assert property (p_level) else $error("pin level not driven"); // see RULE2

  property p_mux;
    st_r.sfcfg[gsfs_pkg::SF_MUX] |=> gpio_out[1:0] == $past(outside_selector_field_field);
  endproperty
  a_mux: assert property (p_mux) else $error("mux pins wrong"); // see RULE4

  property p_busy;
    st_r.sfcfg[gsfs_pkg::SF_BUSY] && cal_busy ##1 st_r.sfcfg[gsfs_pkg::SF_BUSY] |-> gpio_out[2];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not shown"); // see RULE5

  property p_fault;
    st_r.sfcfg[gsfs_pkg::SF_FAULT] |=> gpio_out[3] == $past(|err_flags);
  endproperty
  a_fault: assert property (p_fault) else $error("fault pin wrong"); // see RULE6

  // Cycles between chopping clock rises, trusted after two rises clear of outside mode
  localparam int CHOP_CYC = gsfs_pkg::CHOP_DIV * gsfs_pkg::MCLK_DIV;
  logic chop_d_r;
  logic chop_arm_r;
  logic chop_ok_r;
  logic [9:0] chop_gap_r;
  logic chop_rise;
  assign chop_rise = st_r.chop & ~chop_d_r;
  always_ff @(posedge clk) begin
    chop_d_r <= st_r.chop;
    if (srst || ext_mode) begin
      chop_arm_r <= 1'b0;
      chop_ok_r <= 1'b0;
      chop_gap_r <= 10'h000;
    end else if (chop_rise) begin
      chop_arm_r <= 1'b1;
      chop_ok_r <= chop_arm_r;
      chop_gap_r <= 10'h001;
    end else if (chop_gap_r != 10'h3FF) begin
      chop_gap_r <= 10'(chop_gap_r + 1'b1);
    end
  end

  property p_chop;
    chop_rise && chop_ok_r |-> chop_gap_r == 10'(CHOP_CYC);
  endproperty
  a_chop: assert property (p_chop) else $error("chop period wrong"); // see RULE7

  property p_clkout;
    clk_on |=> gpio_out[4] ==
      $past(st_r.sync[gsfs_pkg::SY_CLKSEL] ? st_r.chop : st_r.mclk);
  endproperty
  a_clkout: assert property (p_clkout) else $error("clock out wrong"); // see RULE9

  property p_block;
    (st_r.chain & pin_sf(st_r.sfcfg, st_r.dir)) == 8'h00 && (st_r.chain & ~st_r.dir) == 8'h00;
  endproperty
  a_block: assert property (p_block) else $error("chain on busy pin"); // see RULE13

  property p_adv;
    st_r.ptr != $past(st_r.ptr) |-> $past(cs_rise || cfg_chg);
  endproperty
  a_adv: assert property (p_adv) else $error("pointer moved early"); // see RULE20

  property p_round;
    cs_rise && !cfg_chg && st_r.ptr == gsfs_pkg::PTR_DEV |=>
      st_r.ptr == next_chain($past(st_r.chain), gsfs_pkg::PTR_DEV);
  endproperty
  a_round: assert property (p_round) else $error("round not restarted"); // see RULE15

  property p_mirror;
    st_r.chain[0] && st_r.ptr == 3'h0 && !cfg_chg |=> gpio_out[0] == $past(cs_s);
  endproperty
  a_mirror: assert property (p_mirror) else $error("select not routed"); // see RULE14

  property p_sdo;
    !sdo_oe_n |-> $past(st_r.ptr) == gsfs_pkg::PTR_DEV && !$past(cs_s);
  endproperty
  a_sdo: assert property (p_sdo) else $error("serial output driven"); // see RULE16

  c_chain_dev: cover property (st_r.chain != 8'h00 && !core_cs_n);
  c_clkout: cover property (clk_on && $rose(gpio_out[4]));
  c_ext: cover property (ext_mode && master_tick);
endmodule // gsfs_top
`default_nettype wire

//--- sim/gsfs_host_model.sv
// Host select driver that also watches which target follows each pulse
`default_nettype none
module gsfs_host_model (
  input wire logic clk,
  input wire logic [3:0] sel_n,
  output logic host_cs_n,
  output logic [3:0] seen
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    host_cs_n = 1'b1;
    seen = 4'h0;
  end
  // One select pulse of 11 cycles, then a gap of 6
  task automatic pulse();
    int k;
    @(posedge clk);
    host_cs_n <= 1'b0;
    seen = 4'h0;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (k == 10) begin
        host_cs_n <= 1'b1;
      end
      #1;
      seen = seen | ~sel_n;
    end
  endtask
endmodule // gsfs_host_model
`default_nettype wire

//--- sim/gsfs_top_tb_top.sv
// Bench for the pin block
`default_nettype none
module gsfs_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] e;} gsfs_row_s;
  logic clk, srst, ext_clk, reg_wr, host_cs_n, core_cs_n, sdo_core, sdo_out, sdo_oe_n;
  logic cal_busy, master_tick;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic [6:0] gpio_in, gpio_out, gpio_oe_n;
  logic [1:0] outside_selector_field_field;
  logic [15:0] err_flags;
  logic [3:0] seen;
  logic [3:0] exp_seq [5] = '{4'hC, 4'h1, 4'h2, 4'hC, 4'h1};
  gsfs_row_s rows [7] = '{
    '{gsfs_pkg::REG_DIR, 8'h7F, 8'h7F}, '{gsfs_pkg::REG_SFCFG, 8'hFF, 8'h1F},
    '{gsfs_pkg::REG_SYNC, 8'hA5, 8'hA5}, '{3'h5, 8'hFF, 8'h00},
    '{gsfs_pkg::REG_SFCFG, 8'h00, 8'h00}, '{gsfs_pkg::REG_DIR, 8'h00, 8'h00},
    '{gsfs_pkg::REG_CHAIN, 8'h01, 8'h00}};
  int err_count, check_count, n, i;
  gsfs_top i_gsfs_top (.clk(clk), .srst(srst), .ext_clk(ext_clk), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .host_cs_n(host_cs_n),
    .core_cs_n(core_cs_n), .sdo_core(sdo_core), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .outside_selector_field_field(outside_selector_field_field), .cal_busy(cal_busy), .err_flags(err_flags),
    .master_tick(master_tick));
  gsfs_host_model i_gsfs_host_model (.clk(clk), .sel_n({sdo_oe_n, core_cs_n, gpio_out[1:0]}),
    .host_cs_n(host_cs_n), .seen(seen));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Outside clock, 80 ns, off the system clock's phase
  initial begin
    ext_clk = 1'b0;
    #3;
    forever #40 ext_clk = ~ext_clk;
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    rd = reg_rdata;
  endtask
  // Cycles between two rises of the clock pin (w=0) or the master tick (w=1)
  task automatic per(input int w);
    int r, k;
    logic p, c;
    r = 0;
    n = 0;
    p = 1'b1;
    for (k = 0; k < 3000 && r < 2; k++) begin
      @(posedge clk);
      #1;
      c = w ? master_tick : gpio_out[4];
      if (r == 1) n++;
      if (c && !p) r++;
      p = c;
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #500us;
    err_count++;
    results();
  end
  initial begin
    err_count = 0;
    check_count = 0;
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    gpio_in = 7'h00;
    sdo_core = 1'b0;
    outside_selector_field_field = 2'h0;
    cal_busy = 1'b0;
    err_flags = 16'h0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("oe_n", gpio_oe_n, 7'h7F);
    chk("cs", {core_cs_n, sdo_oe_n}, 2'h3);
    for (i = 0; i < 5; i++) begin
      rdr(3'(i));
      chk("reset reg", rd, 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdr(rows[i].a);
      chk("reg", rd, rows[i].e);
    end
    wr(gsfs_pkg::REG_DIR, 8'h0F);
    wr(gsfs_pkg::REG_LEVEL, 8'h05);
    gpio_in <= 7'h50;
    repeat (5) @(posedge clk);
    #1;
    chk("oe_n", gpio_oe_n, 7'h70);
    chk("out", gpio_out[3:0], 4'h5);
    rdr(gsfs_pkg::REG_LEVEL);
    chk("in", rd & 8'h70, 8'h50);
    wr(gsfs_pkg::REG_SFCFG, 8'h07);
    outside_selector_field_field <= 2'h2;
    cal_busy <= 1'b1;
    err_flags <= 16'h0100;
    repeat (4) @(posedge clk);
    #1;
    chk("special", gpio_out[3:0], 4'hE);
    cal_busy <= 1'b0;
    err_flags <= 16'h0;
    repeat (4) @(posedge clk);
    #1;
    chk("special off", gpio_out[3:0], 4'h2);
    per(1);
    chk("tick", n, 100);
    wr(gsfs_pkg::REG_DIR, 8'h10);
    wr(gsfs_pkg::REG_SFCFG, 8'h08);
    wr(gsfs_pkg::REG_SYNC, 8'h00);
    per(0);
    chk("mclk out", n, 100);
    wr(gsfs_pkg::REG_SYNC, 8'h40);
    per(0);
    chk("chop out", n, 800);
    wr(gsfs_pkg::REG_DIR, 8'h00);
    wr(gsfs_pkg::REG_SFCFG, 8'h10);
    wr(gsfs_pkg::REG_SYNC, 8'h81);
    repeat (48) @(posedge clk);
    per(1);
    chk("ext rise", n, 8);
    wr(gsfs_pkg::REG_SYNC, 8'h02);
    repeat (48) @(posedge clk);
    per(1);
    chk("ext fall", n, 16);
    wr(gsfs_pkg::REG_SFCFG, 8'h00);
    wr(gsfs_pkg::REG_DIR, 8'h03);
    wr(gsfs_pkg::REG_LEVEL, 8'h03);
    wr(gsfs_pkg::REG_CHAIN, 8'h07);
    rdr(gsfs_pkg::REG_CHAIN);
    chk("chain", rd, 8'h03);
    for (i = 0; i < 5; i++) begin
      i_gsfs_host_model.pulse();
      chk("target", seen, exp_seq[i]);
    end
    sdo_core <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("sdo", sdo_out, 1'b1);
    wr(gsfs_pkg::REG_CHAIN, 8'h00);
    i_gsfs_host_model.pulse();
    chk("unchained", seen, 4'hC);
    results();
  end
endmodule // gsfs_top_tb_top
`default_nettype wire
